// ==== verification/crsb_checker.sv ====
// Purpose: port assertions for the cpu reset and irq sideband
// Assumes: mode strap held steady across each reset
// Notes: binds into the top module
module crsb_checker
    import crsb_pkg::*;
#(
    parameter int HARD_RESET_CYCLES = HARD_RESET_CLKS
)
(
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    input wire logic mode_strap_in,
    input wire logic cpu_shutdown_in,
    input wire logic refresh_req_in,
    input wire logic cpu_init_out,
    input wire logic mode_shared_n_out,
    input wire logic legacy_bus_reset_out,
    input wire logic pci_reset_n_out,
    input wire logic [1:0] bus_grant_out
);
    logic [1:0] st_cnt;
    logic alt;
    int low_cnt;
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_b_in);
    always_ff @(posedge clk_sys_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            st_cnt <= 2'h0;
            low_cnt <= 0;
        end
        else
        begin
            st_cnt <= st_cnt + {1'b0, st_cnt != 2'h3};
            low_cnt <= mode_shared_n_out ? 0 : low_cnt + 1;
        end
    end
    // strap is only trusted while the reset state lasts
    always_ff @(posedge clk_sys_in)
        if (st_cnt != 2'h3)
            alt <= mode_strap_in;
    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    sequence init_four;
        cpu_init_out [*4];
    endsequence
    sequence hard_low;
        !mode_shared_n_out [*8];
    endsequence
    shutdown_init_a: assert property (st_cnt == 2'h3 && !alt && cpu_shutdown_in
        |=> init_four) else $error("init short");
    alt_no_init_a: assert property (st_cnt == 2'h3 && alt |-> !cpu_init_out)
        else $error("init in alt");
    shutdown_hard_a: assert property (st_cnt == 2'h3 && alt && cpu_shutdown_in
        |=> hard_low) else $error("hard reset short");
    hard_len_a: assert property (alt && $rose(mode_shared_n_out)
        |-> low_cnt >= HARD_RESET_CYCLES) else $error("hard reset length");
    pci_inverse_a: assert property (pci_reset_n_out == !legacy_bus_reset_out)
        else $error("pci reset");
    bus_reset_alt_a: assert property (st_cnt == 2'h3 && !alt |-> !legacy_bus_reset_out)
        else $error("bus reset legacy");
    grant_idle_a: assert property (bus_grant_out != GR_NONE
        |=> $stable(bus_grant_out) || bus_grant_out == GR_NONE)
        else $error("owner change");
    refresh_first_a: assert property (bus_grant_out == GR_NONE && refresh_req_in
        |=> bus_grant_out == GR_REFRESH) else $error("refresh grant");
endmodule // crsb_checker

bind crsb_sideband crsb_checker #(.HARD_RESET_CYCLES(HARD_RESET_CYCLES)) i_chk
(
    .clk_sys_in(clk_sys_in),
    .rst_b_in(rst_b_in),
    .mode_strap_in(mode_strap_in),
    .cpu_shutdown_in(cpu_shutdown_in),
    .refresh_req_in(refresh_req_in),
    .cpu_init_out(cpu_init_out),
    .mode_shared_n_out(mode_shared_n_out),
    .legacy_bus_reset_out(legacy_bus_reset_out),
    .pci_reset_n_out(pci_reset_n_out),
    .bus_grant_out(bus_grant_out)
);

// ==== verification/crsb_host_model.sv ====
// Purpose: host processor seen from the sideband
// Assumes: one-cycle shutdown requests
// Notes: records the length of the last init and hard reset pulse
module crsb_host_model
(
    input wire logic clk_sys_in,
    input wire logic shut_req_in,
    input wire logic init_in,
    input wire logic cpu_hard_reset_n_n_in,
    output logic shutdown_out,
    output int init_len_out,
    output int hr_len_out
);
    timeunit 1ns;
    timeprecision 1ns;
    int ic = 0;
    int hc = 0;
    initial shutdown_out = 1'b0;
    always @(posedge clk_sys_in)
    begin
        shutdown_out <= shut_req_in;
        ic <= init_in ? ic + 1 : 0;
        hc <= cpu_hard_reset_n_n_in ? 0 : hc + 1;
        if (!init_in && ic != 0)
            init_len_out <= ic;
        if (cpu_hard_reset_n_n_in && hc != 0)
            hr_len_out <= hc;
    end
endmodule // crsb_host_model

// ==== verification/tb.sv ====
// Purpose: self-checking bench for the cpu reset and irq sideband
// Assumes: hard reset length cut to 20 clocks
// Notes: legacy mode first; a second reset enters alternate mode
module tb
    import crsb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int HR = 20;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic strap = 1'b0;
    logic shut_req = 1'b0;
    logic pci = 1'b0;
    logic rfr = 1'b0;
    logic [7:0] dma = 8'h00;
    logic [15:0] irq = 16'h0100;
    logic [31:0] hrdata, q;
    logic hready, shut, init, hr_n, bus_rst, pci_rst_n, intr, evt, wide;
    logic [1:0] gnt;
    logic [2:0] ack;
    int hr_len, init_len, r;
    int failures = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [31:0] model [int];
    crsb_sideband #(.HARD_RESET_CYCLES(HR)) i_dut
    (
        .clk_sys_in(clk),
        .rst_b_in(rst_b),
        .hsel_in(hsel),
        .haddr_in(haddr),
        .htrans_in(htrans),
        .hwrite_in(hwrite),
        .hsize_in(3'h2),
        .hwdata_in(hwdata),
        .hready_in(hready),
        .hreadyout_out(hready),
        .hresp_out(),
        .hrdata_out(hrdata),
        .power_good_in(1'b1),
        .mode_strap_in(strap),
        .cpu_shutdown_in(shut),
        .coproc_error_in_n(1'b1),
        .irq_pin_in(irq),
        .timer_zero_output_in(1'b0),
        .pci_req_in(pci),
        .refresh_req_in(rfr),
        .dma_req_in(dma),
        .cpu_init_out(init),
        .mode_shared_n_out(hr_n),
        .legacy_bus_reset_out(bus_rst),
        .pci_reset_n_out(pci_rst_n),
        .cpu_intr_out(intr),
        .bus_grant_out(gnt),
        .dma_ack_chan_out(ack),
        .dma_wide_out(wide),
        .event_irq_out(evt)
    );
    crsb_host_model i_host
    (
        .clk_sys_in(clk),
        .shut_req_in(shut_req),
        .init_in(init),
        .cpu_hard_reset_n_n_in(hr_n),
        .shutdown_out(shut),
        .init_len_out(init_len),
        .hr_len_out(hr_len)
    );
    always #5 clk = ~clk;
    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic end_of_test();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
        checks_done++;
        if (s !== e)
        begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, s);
        end
    endtask
    // read data taken at the data-phase edge
    task automatic bus(input logic w, input logic [15:0] idx, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {14'h0, idx, 2'h0};
        step(1);
        while (!hready) step(1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        step(1);
        while (!hready) step(1);
        q = hrdata;
        if (w)
            model[idx] = d & 32'hff;
    endtask
    task automatic pulse();
        shut_req <= 1'b1;
        step(1);
        shut_req <= 1'b0;
    endtask
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 2000)
        begin
            failures++;
            end_of_test();
        end
    end
    initial
    begin
        void'($urandom(32'h3408d3cd));
        step(10);
        rst_b <= 1'b1;
        step(5);
        chk("idle intr", 0, intr);
        bus(1'b1, IDX_INT_MASK, 32'hf);
        bus(1'b1, IDX_HOT_RESET, 32'h1);
        step(20);
        chk("init len", INIT_PULSE_CLKS, init_len);
        chk("event irq", 1, evt);
        bus(1'b0, IDX_INT_STAT, 32'h0);
        chk("stat init", 1, q[EV_INIT]);
        step(2);
        chk("event clear", 0, evt);
        bus(1'b1, IDX_INT_MASK, 32'h0);
        pulse();
        step(1);
        pulse();
        step(20);
        chk("retrigger len", INIT_PULSE_CLKS + 2, init_len);
        chk("masked event", 0, evt);
        bus(1'b1, IDX_INT_MASK, 32'hf);
        step(2);
        chk("unmasked event", 1, evt);
        bus(1'b0, IDX_INT_STAT, 32'h0);
        chk("stat shutdown", 1, q[EV_SHUTDOWN]);
        bus(1'b1, IDX_SYS_CTRL, 32'h2);
        step(20);
        chk("kbd init len", INIT_PULSE_CLKS, init_len);
        chk("ignore error", 1, hr_n);
        $display("test legacy done");
        r = $urandom & 32'hfe;
        bus(1'b1, IDX_TRIG_HI, r);
        bus(1'b0, IDX_TRIG_HI, 32'h0);
        chk("trigger high", model[IDX_TRIG_HI], q);
        bus(1'b0, 16'h0003, 32'h0);
        chk("unmapped", 0, q);
        irq[5] <= 1'b1;
        step(1);
        irq[5] <= 1'b0;
        step(6);
        chk("rise latch", 1, intr);
        bus(1'b1, IDX_IRQ_PEND, 32'h20);
        step(2);
        chk("rise clear", 0, intr);
        irq[8] <= 1'b0;
        step(6);
        chk("fall latch", 1, intr);
        bus(1'b1, IDX_IRQ_PEND, 32'h100);
        step(2);
        chk("fall clear", 0, intr);
        irq[8] <= 1'b1;
        $display("test interrupts done");
        rfr <= 1'b1;
        dma <= 8'h20;
        pci <= 1'b1;
        step(3);
        chk("grant refresh", GR_REFRESH, gnt);
        rfr <= 1'b0;
        step(3);
        chk("grant dma", {GR_DMA, 3'h5, 1'b1}, {gnt, ack, wide});
        dma <= 8'h00;
        step(3);
        chk("grant pci", GR_PCI, gnt);
        pci <= 1'b0;
        $display("test arbiter done");
        strap <= 1'b1;
        rst_b <= 1'b0;
        step(10);
        rst_b <= 1'b1;
        step(5);
        bus(1'b1, IDX_HOT_RESET, 32'h1);
        step(3);
        chk("bus reset", 2'b10, {bus_rst, pci_rst_n});
        step(40);
        chk("hard reset len", HR, hr_len);
        $display("test alternate done");
        end_of_test();
    end
endmodule // tb

// ==== verilog/crsb_irq_detect.sv ====
// Purpose: per-channel edge or level request detection
// Assumes: request inputs already synchronised to the clock
// Notes: channels in FALL_MASK use falling edge and active-low level

module crsb_irq_detect
#(
    parameter int N = 16,
    parameter logic [15:0] FALL_MASK = 16'h2100
)
(
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    input wire logic [N-1:0] req_in,
    input wire logic [N-1:0] level_mode_in,
    input wire logic [N-1:0] clear_in,
    output logic [N-1:0] pending_out
);
    initial
    begin
        if (N < 1 || N > 16)
        begin
            $error("N out of range");
        end
    end

    genvar i;
    generate
        for (i = 0; i < N; i++)
        begin : g_chan
            logic prev;
            logic latched;
            logic asserted;
            logic edge_seen;
            assign asserted = FALL_MASK[i] ? ~req_in[i] : req_in[i];
            assign edge_seen = FALL_MASK[i] ? (prev & ~req_in[i]) : (~prev & req_in[i]);
            always_ff @(posedge clk_sys_in or negedge rst_b_in)
            begin
                if (!rst_b_in)
                begin
                    prev <= FALL_MASK[i];
                    latched <= 1'b0;
                end
                else
                begin
                    prev <= req_in[i];
                    // a new edge wins over a clear in the same cycle
                    latched <= edge_seen | (latched & ~clear_in[i]);
                end
            end
            always_ff @(posedge clk_sys_in or negedge rst_b_in)
            begin
                if (!rst_b_in)
                begin
                    pending_out[i] <= 1'b0;
                end
                else
                begin
                    pending_out[i] <= level_mode_in[i] ? asserted : (edge_seen | latched);
                end
            end
        end
    endgenerate

endmodule // crsb_irq_detect

// ==== verilog/crsb_pkg.sv ====
// Purpose: shared constants for the cpu reset and interrupt sideband block
// Assumes: 100 MHz clock, which is also the pci clock; 32-bit ahb-lite register bus
// Notes: byte address is four times the index

package crsb_pkg;

    // ----------------------------------------------------------------
    // register indexes
    // ----------------------------------------------------------------
    localparam int CRSB_IDX_W = 16;
    localparam logic [15:0] IDX_HOT_RESET = 16'h0092;
    localparam logic [15:0] IDX_SYS_CTRL = 16'h004e;
    localparam logic [15:0] IDX_TRIG_LO = 16'h04d0;
    localparam logic [15:0] IDX_TRIG_HI = 16'h04d1;
    localparam logic [15:0] IDX_CLK_DIV = 16'h0040;
    localparam logic [15:0] IDX_IRQ_PEND = 16'h0041;
    localparam logic [15:0] IDX_INT_STAT = 16'h0042;
    localparam logic [15:0] IDX_INT_MASK = 16'h0043;
    localparam logic [15:0] IDX_STATUS = 16'h0044;
    localparam logic [15:0] IDX_CPU_CTRL = 16'h0045;

    // ----------------------------------------------------------------
    // field positions and reset values
    // ----------------------------------------------------------------
    localparam int HOT_RESET_BIT = 0;
    localparam int KBD_RESET_BIT = 1;
    localparam int COPROC_EN_BIT = 4;
    localparam int RESET_DRIVE_BIT = 3;
    localparam int IGNORE_NUMERIC_ERROR_N_EN_BIT = 0;
    localparam logic [7:0] REG8_RESET = 8'h00;
    localparam logic [15:0] IRQ_FALL_MASK = 16'h2100;
    localparam int EV_INIT = 0;
    localparam int EV_CPU_HARD_RESET_N = 1;
    localparam int EV_SHUTDOWN = 2;
    localparam int EV_POWER_GOOD_IN = 3;
    localparam int EV_W = 4;
    localparam logic [2:0] DMA_ACK_IDLE = 3'h4;
    localparam logic [7:0] DMA_CHAN_MASK = 8'hef;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int INIT_PULSE_CLKS = 4;
    localparam int HARD_RESET_TIME_NS = 1000000;
    localparam int HARD_RESET_CLKS = HARD_RESET_TIME_NS / CLK_PERIOD_NS;
    localparam int STRAP_SETTLE_CLKS = 3;

    typedef enum logic {ST_RESET = 1'b0, ST_ACTIVE = 1'b1} crsb_state_t;
    typedef enum logic [1:0]
    {
        GR_NONE = 2'b00,
        GR_PCI = 2'b01,
        GR_REFRESH = 2'b10,
        GR_DMA = 2'b11
    } crsb_grant_t;

endpackage

// ==== verilog/crsb_pulse_stretch.sv ====
// Purpose: retriggerable fixed-length pulse
// Assumes: trigger is a one-cycle pulse on the same clock
// Notes: output rises the cycle after a trigger and lasts LEN cycles

module crsb_pulse_stretch
#(
    parameter int LEN = 4
)
(
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    input wire logic trig_in,
    output logic active_out
);
    localparam int CW = $clog2(LEN + 1);
    localparam logic [CW-1:0] LEN_C = CW'(LEN);

    logic [CW-1:0] count;

    initial
    begin
        if (LEN < 1)
        begin
            $error("LEN below 1");
        end
    end

    // a fresh trigger reloads, so the pulse runs full length
    always_ff @(posedge clk_sys_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            count <= '0;
            active_out <= 1'b0;
        end
        else if (trig_in)
        begin
            count <= LEN_C;
            active_out <= 1'b1;
        end
        else if (count == CW'(1))
        begin
            count <= '0;
            active_out <= 1'b0;
        end
        else if (count != '0)
        begin
            count <= count - CW'(1);
        end
    end

endmodule // crsb_pulse_stretch

// ==== verilog/crsb_sideband.sv ====
// Purpose: cpu reset, initialise, interrupt and bus-arbitration sideband logic
// Assumes: clk_sys_in is the pci clock; power-good, strap, error and irq pins pass a two-flop synchroniser
// Notes: zero-wait ahb-lite slave
//
// Our own choices: the AHB-Lite slave port and the address map.

module crsb_sideband
    import crsb_pkg::*;
#(
    parameter int HARD_RESET_CYCLES = HARD_RESET_CLKS
)
(
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic hreadyout_out,
    output logic hresp_out,
    output logic [31:0] hrdata_out,
    input wire logic power_good_in,
    input wire logic mode_strap_in,
    input wire logic cpu_shutdown_in,
    input wire logic coproc_error_in_n,
    input wire logic [15:0] irq_pin_in,
    input wire logic timer_zero_output_in,
    input wire logic pci_req_in,
    input wire logic refresh_req_in,
    input wire logic [7:0] dma_req_in,
    output logic cpu_init_out,
    output logic mode_shared_n_out,
    output logic legacy_bus_reset_out,
    output logic pci_reset_n_out,
    output logic cpu_intr_out,
    output logic [1:0] bus_grant_out,
    output logic [2:0] dma_ack_chan_out,
    output logic dma_wide_out,
    output logic event_irq_out
);
    initial
    begin
        if (HARD_RESET_CYCLES < 1)
        begin
            $error("HARD_RESET_CYCLES below 1");
        end
    end

    function automatic logic hit(input logic [15:0] idx, input logic [15:0] want);
        hit = (idx == want);
    endfunction

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [18:0] sync_a;
    logic [18:0] sync_b;
    always_ff @(posedge clk_sys_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            sync_a <= 19'h10100;
            sync_b <= 19'h10100;
        end
        else
        begin
            sync_a <= {power_good_in, mode_strap_in, coproc_error_in_n, irq_pin_in};
            sync_b <= sync_a;
        end
    end

    logic power_good_in_s;
    logic strap_s;
    logic coproc_err_s_n;
    logic [15:0] irq_s;
    assign {power_good_in_s, strap_s, coproc_err_s_n, irq_s} = sync_b;

    // ----------------------------------------------------------------
    // operating state and strap latch
    // ----------------------------------------------------------------
    crsb_state_t state;
    logic [1:0] settle;
    logic alt_mode;
    always_ff @(posedge clk_sys_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            state <= ST_RESET;
            settle <= '0;
            alt_mode <= 1'b0;
        end
        else
        begin
            unique case (state)
                ST_RESET:
                begin
                    // let the synchroniser carry the strap first
                    settle <= settle + 2'h1;
                    if (settle == 2'(STRAP_SETTLE_CLKS - 1))
                    begin
                        alt_mode <= strap_s;
                        state <= ST_ACTIVE;
                    end
                end
                ST_ACTIVE:
                begin
                    state <= ST_ACTIVE;
                end
            endcase
        end
    end

    logic active;
    assign active = (state == ST_ACTIVE);

    // ----------------------------------------------------------------
    // ahb-lite slave
    // ----------------------------------------------------------------
    logic take;
    logic wr_q;
    logic rd_q;
    logic [15:0] idx_q;
    logic [15:0] idx_a;
    assign take = hsel_in & htrans_in[1] & hready_in;
    assign idx_a = haddr_in[17:2];
    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;

    always_ff @(posedge clk_sys_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            idx_q <= '0;
        end
        else
        begin
            wr_q <= take & hwrite_in & active;
            rd_q <= take & ~hwrite_in;
            if (take)
            begin
                idx_q <= idx_a;
            end
        end
    end

    logic [7:0] hot_reset_reg;
    logic [7:0] sys_ctrl;
    logic [7:0] trig_lo;
    logic [7:0] trig_hi;
    logic [7:0] clk_div;
    logic [7:0] cpu_ctrl;
    logic [EV_W-1:0] int_stat;
    logic [EV_W-1:0] int_mask;
    logic [15:0] irq_pend;
    logic [7:0] wbyte;
    assign wbyte = hwdata_in[7:0];

    logic hot_set;
    logic kbd_set;
    logic drive_set;
    assign hot_set = wr_q & hit(idx_q, IDX_HOT_RESET) & wbyte[HOT_RESET_BIT]
        & ~hot_reset_reg[HOT_RESET_BIT];
    assign kbd_set = wr_q & hit(idx_q, IDX_SYS_CTRL) & wbyte[KBD_RESET_BIT]
        & ~sys_ctrl[KBD_RESET_BIT];
    assign drive_set = wr_q & hit(idx_q, IDX_CLK_DIV) & wbyte[RESET_DRIVE_BIT]
        & ~clk_div[RESET_DRIVE_BIT];

    always_ff @(posedge clk_sys_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            hot_reset_reg <= REG8_RESET;
            sys_ctrl <= REG8_RESET;
            trig_lo <= REG8_RESET;
            trig_hi <= REG8_RESET;
            clk_div <= REG8_RESET;
            cpu_ctrl <= REG8_RESET;
            int_mask <= '0;
        end
        else if (wr_q)
        begin
            if (hit(idx_q, IDX_HOT_RESET))
                hot_reset_reg <= wbyte;
            if (hit(idx_q, IDX_SYS_CTRL))
                sys_ctrl <= wbyte;
            if (hit(idx_q, IDX_TRIG_LO))
                trig_lo <= wbyte;
            if (hit(idx_q, IDX_TRIG_HI))
                trig_hi <= wbyte;
            if (hit(idx_q, IDX_CLK_DIV))
                clk_div <= wbyte;
            if (hit(idx_q, IDX_CPU_CTRL))
                cpu_ctrl <= wbyte;
            if (hit(idx_q, IDX_INT_MASK))
                int_mask <= hwdata_in[EV_W-1:0];
        end
    end

    // ----------------------------------------------------------------
    // reset and initialise pulses
    // ----------------------------------------------------------------
    logic power_good_in_prev;
    logic power_good_in_rise;
    always_ff @(posedge clk_sys_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            power_good_in_prev <= 1'b0;
        else
            power_good_in_prev <= power_good_in_s;
    end
    assign power_good_in_rise = power_good_in_s & ~power_good_in_prev & active;

    logic cpu_event;
    logic init_trig;
    logic cpu_hard_reset_n_trig;
    logic bus_reset_trig;
    logic init_active;
    logic cpu_hard_reset_n_active;
    logic bus_reset_active;
    assign cpu_event = hot_set | kbd_set | (cpu_shutdown_in & active);
    assign init_trig = ~alt_mode & cpu_event;
    assign cpu_hard_reset_n_trig = alt_mode & (cpu_event | power_good_in_rise);
    assign bus_reset_trig = alt_mode & (power_good_in_rise | hot_set | drive_set);

    crsb_pulse_stretch #(.LEN(INIT_PULSE_CLKS)) u_init_pulse
    (
        .clk_sys_in(clk_sys_in),
        .rst_b_in(rst_b_in),
        .trig_in(init_trig),
        .active_out(init_active)
    );

    crsb_pulse_stretch #(.LEN(HARD_RESET_CYCLES)) u_cpu_hard_reset_n_pulse
    (
        .clk_sys_in(clk_sys_in),
        .rst_b_in(rst_b_in),
        .trig_in(cpu_hard_reset_n_trig),
        .active_out(cpu_hard_reset_n_active)
    );

    crsb_pulse_stretch #(.LEN(HARD_RESET_CYCLES)) u_bus_reset_pulse
    (
        .clk_sys_in(clk_sys_in),
        .rst_b_in(rst_b_in),
        .trig_in(bus_reset_trig),
        .active_out(bus_reset_active)
    );

    logic cpu_hard_reset_n;
    logic ignore_numeric_error_n;
    logic coproc_mode;
    assign coproc_mode = sys_ctrl[COPROC_EN_BIT];
    // ignore-error only when software allows it
    assign ignore_numeric_error_n = ~(coproc_mode & ~coproc_err_s_n & cpu_ctrl[IGNORE_NUMERIC_ERROR_N_EN_BIT]);
    assign cpu_hard_reset_n = ~cpu_hard_reset_n_active;
    assign cpu_init_out = init_active;
    assign mode_shared_n_out = alt_mode ? cpu_hard_reset_n : ignore_numeric_error_n;
    assign legacy_bus_reset_out = alt_mode & bus_reset_active;
    assign pci_reset_n_out = ~legacy_bus_reset_out;

    // ----------------------------------------------------------------
    // cascaded interrupt controllers
    // ----------------------------------------------------------------
    logic [15:0] irq_req;
    logic [15:0] irq_clear;
    logic irq_line_thirteen;
    // pin feeds channel 13 in both modes; ignore-error is not mixed in
    assign irq_line_thirteen = coproc_err_s_n;
    assign irq_req = {irq_s[15:14], irq_line_thirteen, irq_s[12:3], 1'b0, irq_s[1],
        timer_zero_output_in};
    assign irq_clear = (wr_q & hit(idx_q, IDX_IRQ_PEND)) ? hwdata_in[15:0] : 16'h0000;

    crsb_irq_detect #(.N(16), .FALL_MASK(IRQ_FALL_MASK)) u_irq_detect
    (
        .clk_sys_in(clk_sys_in),
        .rst_b_in(rst_b_in),
        .req_in(irq_req),
        .level_mode_in({trig_hi, trig_lo}),
        .clear_in(irq_clear),
        .pending_out(irq_pend)
    );

    logic slave_any;
    logic [7:0] master_in;
    assign slave_any = |irq_pend[15:8];
    assign master_in = {irq_pend[7:3], slave_any, irq_pend[1:0]};
    assign cpu_intr_out = |master_in;

    // ----------------------------------------------------------------
    // bus arbiter and dma channel select
    // ----------------------------------------------------------------
    crsb_grant_t grant;
    logic [2:0] dma_chan;
    logic [7:0] dma_live;
    logic [2:0] dma_pick;
    assign dma_live = dma_req_in & DMA_CHAN_MASK;

    always_comb
    begin
        dma_pick = 3'h0;
        for (int c = 7; c >= 0; c--)
        begin
            if (dma_live[c])
                dma_pick = 3'(c);
        end
    end

    // one owner at a time; one idle cycle between owners
    always_ff @(posedge clk_sys_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            grant <= GR_NONE;
            dma_chan <= DMA_ACK_IDLE;
        end
        else
        begin
            unique case (grant)
                GR_NONE:
                begin
                    if (refresh_req_in)
                        grant <= GR_REFRESH;
                    else if (|dma_live)
                    begin
                        grant <= GR_DMA;
                        dma_chan <= dma_pick;
                    end
                    else if (pci_req_in)
                        grant <= GR_PCI;
                end
                GR_PCI:
                    if (!pci_req_in)
                        grant <= GR_NONE;
                GR_REFRESH:
                    if (!refresh_req_in)
                        grant <= GR_NONE;
                GR_DMA:
                    if (!dma_live[dma_chan])
                    begin
                        grant <= GR_NONE;
                        dma_chan <= DMA_ACK_IDLE;
                    end
            endcase
        end
    end
    assign bus_grant_out = grant;
    assign dma_ack_chan_out = dma_chan;
    assign dma_wide_out = (grant == GR_DMA) & dma_chan[2];

    // ----------------------------------------------------------------
    // event status, mask and read path
    // ----------------------------------------------------------------
    logic [EV_W-1:0] ev;
    logic [EV_W-1:0] stat_clr;
    assign ev = {power_good_in_rise, cpu_shutdown_in & active, cpu_hard_reset_n_trig, init_trig};
    // clear only bits the reader saw, so a later event survives
    assign stat_clr = (rd_q & hit(idx_q, IDX_INT_STAT)) ? hrdata_out[EV_W-1:0] : '0;

    always_ff @(posedge clk_sys_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            int_stat <= '0;
        else
            int_stat <= ev | (int_stat & ~stat_clr);
    end
    assign event_irq_out = |(int_stat & int_mask);

    logic [31:0] rd_mux;
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        unique case (1'b1)
            hit(idx_a, IDX_HOT_RESET): rd_mux[7:0] = hot_reset_reg;
            hit(idx_a, IDX_SYS_CTRL): rd_mux[7:0] = sys_ctrl;
            hit(idx_a, IDX_TRIG_LO): rd_mux[7:0] = trig_lo;
            hit(idx_a, IDX_TRIG_HI): rd_mux[7:0] = trig_hi;
            hit(idx_a, IDX_CLK_DIV): rd_mux[7:0] = clk_div;
            hit(idx_a, IDX_CPU_CTRL): rd_mux[7:0] = cpu_ctrl;
            hit(idx_a, IDX_IRQ_PEND): rd_mux[15:0] = irq_pend;
            hit(idx_a, IDX_INT_STAT): rd_mux[EV_W-1:0] = int_stat;
            hit(idx_a, IDX_INT_MASK): rd_mux[EV_W-1:0] = int_mask;
            hit(idx_a, IDX_STATUS): rd_mux[15:0] = {dma_chan, grant, ~coproc_err_s_n,
                bus_reset_active, cpu_hard_reset_n_active, init_active, cpu_intr_out, 4'h0, alt_mode,
                active};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_sys_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            hrdata_out <= 32'h0000_0000;
        else if (take & ~hwrite_in)
            hrdata_out <= rd_mux;
    end

endmodule // crsb_sideband
